// ===== inc/rcm_defs.svh
/*
  Constants of the reset and clock monitor: register offsets, field positions,
  key values, reset values and timing figures.
  Assumes a 100 MHz clk_sys; included by rcm_pkg and the design file.
*/
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH

`define RCM_CLK_MHZ        100
`define RCM_T_FILT_US      4000
`define RCM_T_STRETCH_US   4000
`define RCM_SLOW_MISS      3'h4

`define RCM_OFS_CAUSE      16'hA017
`define RCM_OFS_IRQ_STAT   16'hA018
`define RCM_OFS_IRQ_MASK   16'hA019

`define RCM_BIT_CKM_EN     7
`define RCM_BIT_ECC_EN     6
`define RCM_BIT_CLR        4
`define RCM_KEY_HI         3
`define RCM_KEY_LO         0

`define RCM_FLG_KEY        0
`define RCM_FLG_WDG        1
`define RCM_FLG_ECC        2
`define RCM_FLG_CKM        3

`define RCM_KEY_FIRST      4'h5
`define RCM_KEY_SECOND     4'hA
`define RCM_NIB_ZERO       4'h0
`define RCM_BYTE_ZERO      8'h00

`endif

// ===== inc/rcm_pkg.sv
/*
  Types of the reset and clock monitor.
  Assumes rcm_defs.svh is on the include path.
*/
`include "rcm_defs.svh"

package rcm_pkg;
  typedef logic [15:0] rcm_addr_t;
  typedef logic [7:0]  rcm_byte_t;
  typedef logic [3:0]  rcm_nib_t;
  typedef enum logic [1:0] {
    RCM_RUN,
    RCM_HOLD,
    RCM_STRETCH
  } rcm_rst_e;
endpackage

// ===== logic/rcm_top.sv
/*
  Reset controller with system clock presence monitor: glitch filter on the
  external reset pin, reset stretch, pin feedback, key-sequence software
  reset, sticky cause flags, event interrupt with status and mask.
  Assumes all inputs synchronous to clk_sys; ext_reset_pin_n acts as power-on clear;
  watchdogs, ECC checker and voltage detectors sit outside.
*/
// Behaviour
// - in normal mode, four slow clock cycles without system clock activity mean clock fault
// - key, watchdog and fetch ECC resets are software resets
// - power-on, low-voltage, clock fault and pin resets are hardware resets
// - hardware reset clears all control state, software reset only a subset
// - pin low pulses shorter than 4 ms are ignored
// - internal reset stays asserted 4 ms after hardware conditions end
// - internal hardware reset also drives the external pin low
// - clock fault resets only when its enable is set; enable cleared by any reset
// - fetch ECC error resets only when its enable is set; default zero
// - clock fault flag set on clock fault reset, cleared only by power-on or the clear bit
// - ECC flag set on ECC reset, cleared only by power-on or the clear bit
// - watchdog flag set when any of three watchdog flags is set
// - writing clear bit clears four cause flags; bit self-clears
// - key 0101 then 1010 as next write gives software reset; else sequence restarts
// - cause register reads four flags low, upper bits read zero
// - fetch ECC error gives interrupt, or reset when enable is set
`include "rcm_defs.svh"

module rcm_top #(
  parameter int unsigned FILT_CYC    = `RCM_T_FILT_US * `RCM_CLK_MHZ,
  parameter int unsigned STRETCH_CYC = `RCM_T_STRETCH_US * `RCM_CLK_MHZ,
  parameter int unsigned CW          = 19
) (
  input  wire logic              clk_sys,
  input  wire logic              ext_reset_pin_n,
  input  wire rcm_pkg::rcm_addr_t addr,
  input  wire rcm_pkg::rcm_byte_t wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output rcm_pkg::rcm_byte_t     rd_data,
  input  wire logic              slow_osc_clock,
  input  wire logic              system_clock_tick,
  input  wire logic              normal_mode,
  input  wire logic              core_supply_por,
  input  wire logic              low_voltage_detect,
  input  wire logic              ext_reset_pin_n_i,
  output logic                   ext_reset_pin_n_o,
  output logic                   ext_reset_pin_n_oe,
  input  wire logic              wdog_main_flag,
  input  wire logic              wdog_one_flag,
  input  wire logic              wdog_two_flag,
  input  wire logic              ecc_fetch_err,
  output logic                   hw_reset_n,
  output logic                   sw_reset,
  output logic                   ecc_irq,
  output logic                   irq
);
  import rcm_pkg::*;

  // clock monitor and reset sequencing state
  logic         slow_prev_q, slow_prev_d;
  logic [2:0]   miss_q, miss_d;
  logic         fault_q, fault_d;
  logic [CW-1:0] filt_q, filt_d;
  logic         pin_rst_q, pin_rst_d;
  logic [CW-1:0] str_q, str_d;
  rcm_rst_e     st_q, st_d;
  logic         hw_n_q, hw_n_d;
  logic         pin_oe_q, pin_oe_d;

  // register state
  logic         ckm_en_q, ckm_en_d;
  logic         ecc_en_q, ecc_en_d;
  logic         armed_q, armed_d;
  rcm_nib_t     flag_q, flag_d;
  rcm_nib_t     stat_q, stat_d;
  rcm_nib_t     mask_q, mask_d;
  logic         sw_q, sw_d;
  logic         eirq_q, eirq_d;
  logic         irq_q, irq_d;
  rcm_byte_t    rd_q, rd_d;

  logic         hw_src;
  logic         ckm_fire;
  logic         ecc_fire;
  logic         wdg_fire;
  logic         key_fire;
  logic         wr_cause;
  logic         hw_enter;

  // sources and decoded strobes
  always_comb begin
    wr_cause = wr_en && (addr == `RCM_OFS_CAUSE);
    ckm_fire = fault_q && ckm_en_q;
    ecc_fire = ecc_fetch_err && ecc_en_q;
    wdg_fire = wdog_main_flag | wdog_one_flag | wdog_two_flag;
    key_fire = wr_cause && armed_q &&
               (wr_data[`RCM_KEY_HI:`RCM_KEY_LO] == `RCM_KEY_SECOND);
    // hardware reset class
    hw_src   = core_supply_por | low_voltage_detect | ckm_fire | pin_rst_q;
    hw_enter = hw_src && (st_q == RCM_RUN);
  end

  // clock monitor, pin filter and stretch
  always_comb begin
    slow_prev_d = slow_osc_clock;
    miss_d      = miss_q;
    fault_d     = fault_q;
    filt_d      = filt_q;
    pin_rst_d   = pin_rst_q;
    str_d       = str_q;
    st_d        = st_q;
    hw_n_d      = hw_n_q;
    pin_oe_d    = pin_oe_q;

    // monitor only counts in normal mode; any activity restarts the count
    if (!normal_mode || system_clock_tick) begin
      miss_d  = 3'h0;
      fault_d = 1'b0;
    end else if (slow_osc_clock && !slow_prev_q && !fault_q) begin
      miss_d = miss_q + 3'h1;
      if (miss_d == `RCM_SLOW_MISS) begin
        fault_d = 1'b1;
      end
    end

    // own drive on the pin must not re-trigger the filter
    if (ext_reset_pin_n_i || pin_oe_q) begin
      filt_d    = '0;
      pin_rst_d = 1'b0;
    end else if (filt_q < CW'(FILT_CYC - 1)) begin
      filt_d = filt_q + CW'(1);
    end else begin
      pin_rst_d = 1'b1;
    end

    case (st_q)
      RCM_RUN: begin
        if (hw_src) begin
          st_d     = RCM_HOLD;
          hw_n_d   = 1'b0;
          pin_oe_d = 1'b1;
        end
      end
      RCM_HOLD: begin
        if (!hw_src) begin
          st_d  = RCM_STRETCH;
          str_d = '0;
        end
      end
      RCM_STRETCH: begin
        if (hw_src) begin
          st_d = RCM_HOLD;
        end else if (str_q < CW'(STRETCH_CYC - 1)) begin
          str_d = str_q + CW'(1);
        end else begin
          st_d     = RCM_RUN;
          hw_n_d   = 1'b1;
          pin_oe_d = 1'b0;
        end
      end
      default: begin
        st_d = RCM_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!ext_reset_pin_n) begin
      slow_prev_q <= 1'b0;
      miss_q      <= 3'h0;
      fault_q     <= 1'b0;
      filt_q      <= '0;
      pin_rst_q   <= 1'b0;
      str_q       <= '0;
      st_q        <= RCM_HOLD;
      hw_n_q      <= 1'b0;
      pin_oe_q    <= 1'b1;
    end else begin
      slow_prev_q <= slow_prev_d;
      miss_q      <= miss_d;
      fault_q     <= fault_d;
      filt_q      <= filt_d;
      pin_rst_q   <= pin_rst_d;
      str_q       <= str_d;
      st_q        <= st_d;
      hw_n_q      <= hw_n_d;
      pin_oe_q    <= pin_oe_d;
    end
  end

  // register file, flags, software reset and interrupt
  always_comb begin
    ckm_en_d = ckm_en_q;
    ecc_en_d = ecc_en_q;
    armed_d  = armed_q;
    flag_d   = flag_q;
    stat_d   = stat_q;
    mask_d   = mask_q;
    sw_d     = 1'b0;
    eirq_d   = 1'b0;
    rd_d     = `RCM_BYTE_ZERO;

    if (wr_cause) begin
      ckm_en_d = wr_data[`RCM_BIT_CKM_EN];
      ecc_en_d = wr_data[`RCM_BIT_ECC_EN];
      armed_d  = (wr_data[`RCM_KEY_HI:`RCM_KEY_LO] == `RCM_KEY_FIRST);
      if (wr_data[`RCM_BIT_CLR]) begin
        flag_d = `RCM_NIB_ZERO;
      end
    end
    if (wr_en && (addr == `RCM_OFS_IRQ_MASK)) begin
      mask_d = wr_data[3:0];
    end

    // status clears on read; a same-cycle event below still wins
    if (rd_en) begin
      case (addr)
        `RCM_OFS_CAUSE: begin
          rd_d = {`RCM_NIB_ZERO, flag_q};
        end
        `RCM_OFS_IRQ_STAT: begin
          rd_d   = {`RCM_NIB_ZERO, stat_q};
          stat_d = `RCM_NIB_ZERO;
        end
        `RCM_OFS_IRQ_MASK: begin
          rd_d = {`RCM_NIB_ZERO, mask_q};
        end
        default: begin
          rd_d = `RCM_BYTE_ZERO;
        end
      endcase
    end

    // software reset class
    if (key_fire || wdg_fire || ecc_fire) begin
      sw_d     = 1'b1;
      ckm_en_d = 1'b0;
      armed_d  = 1'b0;
    end
    if (ecc_fetch_err && !ecc_en_q) begin
      eirq_d = 1'b1;
    end

    // flag sets win over the clear bit
    if (key_fire) begin
      flag_d[`RCM_FLG_KEY] = 1'b1;
      stat_d[`RCM_FLG_KEY] = 1'b1;
    end
    if (wdg_fire) begin
      flag_d[`RCM_FLG_WDG] = 1'b1;
      stat_d[`RCM_FLG_WDG] = 1'b1;
    end
    if (ecc_fire) begin
      flag_d[`RCM_FLG_ECC] = 1'b1;
      stat_d[`RCM_FLG_ECC] = 1'b1;
    end
    if (ckm_fire && hw_enter) begin
      flag_d[`RCM_FLG_CKM] = 1'b1;
      stat_d[`RCM_FLG_CKM] = 1'b1;
    end

    // hardware reset returns all control state; flags survive it
    if (!hw_n_q) begin
      ckm_en_d = 1'b0;
      ecc_en_d = 1'b0;
      armed_d  = 1'b0;
      mask_d   = `RCM_NIB_ZERO;
      sw_d     = 1'b0;
    end
    // of the resets, only power-on clears the cause flags
    if (core_supply_por) begin
      flag_d = `RCM_NIB_ZERO;
      stat_d = `RCM_NIB_ZERO;
    end

    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_sys) begin
    if (!ext_reset_pin_n) begin
      ckm_en_q <= 1'b0;
      ecc_en_q <= 1'b0;
      armed_q  <= 1'b0;
      flag_q   <= `RCM_NIB_ZERO;
      stat_q   <= `RCM_NIB_ZERO;
      mask_q   <= `RCM_NIB_ZERO;
      sw_q     <= 1'b0;
      eirq_q   <= 1'b0;
      irq_q    <= 1'b0;
      rd_q     <= `RCM_BYTE_ZERO;
    end else begin
      ckm_en_q <= ckm_en_d;
      ecc_en_q <= ecc_en_d;
      armed_q  <= armed_d;
      flag_q   <= flag_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      sw_q     <= sw_d;
      eirq_q   <= eirq_d;
      irq_q    <= irq_d;
      rd_q     <= rd_d;
    end
  end

  always_comb begin
    rd_data            = rd_q;
    hw_reset_n         = hw_n_q;
    ext_reset_pin_n_o  = 1'b0;      // open drain: only ever pulls low
    ext_reset_pin_n_oe = pin_oe_q;
    sw_reset           = sw_q;
    ecc_irq            = eirq_q;
    irq                = irq_q;
  end
endmodule

// ===== tb/rcm_top_properties.sv
/* port checker for rcm_top, bound into every instance.
   assumes one clock and ext_reset_pin_n synchronous, active low. */
`include "rcm_defs.svh"
module rcm_top_chk #(
  parameter int unsigned FILT_CYC    = 20,
  parameter int unsigned STRETCH_CYC = 30
) (
  input wire logic               clk_sys,
  input wire logic               ext_reset_pin_n,
  input wire rcm_pkg::rcm_addr_t addr,
  input wire rcm_pkg::rcm_byte_t wr_data,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire rcm_pkg::rcm_byte_t rd_data,
  input wire logic               normal_mode,
  input wire logic               core_supply_por,
  input wire logic               low_voltage_detect,
  input wire logic               ext_reset_pin_n_i,
  input wire logic               ext_reset_pin_n_oe,
  input wire logic               wdog_main_flag,
  input wire logic               wdog_one_flag,
  input wire logic               wdog_two_flag,
  input wire logic               ecc_fetch_err,
  input wire logic               hw_reset_n,
  input wire logic               sw_reset,
  input wire logic               ecc_irq
);
  import rcm_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!ext_reset_pin_n);
  int unsigned lo_q, lo_d, pl_q, pl_d;
  // low-time counters; the pin count ignores our own drive
  always_comb begin
    lo_d = hw_reset_n ? 0 : lo_q + 1;
    pl_d = (ext_reset_pin_n_i || ext_reset_pin_n_oe) ? 0 : pl_q + 1;
  end
  always_ff @(posedge clk_sys) begin
    lo_q <= ext_reset_pin_n ? lo_d : 0;
    pl_q <= ext_reset_pin_n ? pl_d : 0;
  end
  sequence key_w(logic [3:0] k);
    hw_reset_n && wr_en && addr == `RCM_OFS_CAUSE && wr_data[3:0] == k;
  endsequence
  a_rd_upper: assert property (rd_en |=> rd_data[7:4] == 4'h0)
    else $error("upper read bits set");
  a_pin_follow: assert property (ext_reset_pin_n_oe == !hw_reset_n)
    else $error("pin drive differs from reset");
  a_supply_hold: assert property (core_supply_por || low_voltage_detect |=> !hw_reset_n)
    else $error("supply request gave no reset");
  a_stretch_len: assert property ($rose(hw_reset_n) |-> lo_q >= STRETCH_CYC)
    else $error("reset released too early");
  a_pin_filter: assert property ($fell(hw_reset_n) && !normal_mode
    && !$past(core_supply_por || low_voltage_detect) |-> pl_q + 1 >= FILT_CYC)
    else $error("short pin pulse gave reset");
  a_key_fire: assert property (key_w(4'h5) ##1 key_w(4'ha) |=> ##[0:1] sw_reset)
    else $error("key pair gave no reset");
  a_wdog_sw: assert property (hw_reset_n && (wdog_main_flag || wdog_one_flag || wdog_two_flag)
    |=> ##[0:1] sw_reset)
    else $error("watchdog gave no reset");
  a_ecc_route: assert property (hw_reset_n && ecc_fetch_err |=> ##[0:1] (sw_reset || ecc_irq))
    else $error("ecc error gave nothing");
endmodule

bind rcm_top rcm_top_chk #(.FILT_CYC(FILT_CYC), .STRETCH_CYC(STRETCH_CYC)) i_chk (.*);

// ===== tb/rcm_far.sv
/* far side: reset pin with pull-up and r/c tail, slow oscillator,
   system clock activity. assumes clk_sys from the bench. */
module rcm_far #(
  parameter int RC_CYC = 3
) (
  input wire logic clk_sys,
  input wire logic ext_reset_pin_n_o,
  input wire logic ext_reset_pin_n_oe,
  input wire logic push_low,
  input wire logic clk_halt,
  output logic     ext_reset_pin_n_i,
  output logic     slow_osc_clock,
  output logic     system_clock_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int rc_q = 0;
  int div_q = 0;
  always @(posedge clk_sys) begin
    rc_q <= ext_reset_pin_n_oe ? RC_CYC : (rc_q > 0 ? rc_q - 1 : 0);
    div_q <= (div_q + 1) % 16;
  end
  // r/c tail kept shorter than the pin filter, else reset would loop
  assign ext_reset_pin_n_i = !((ext_reset_pin_n_oe && !ext_reset_pin_n_o) || push_low || rc_q > 0);
  assign slow_osc_clock = div_q >= 8;
  assign system_clock_tick = !clk_halt;
endmodule

// ===== tb/rcm_top_tb.sv
/* bench for rcm_top: register, key, watchdog, ecc, pin, clock
   monitor and supply tests; assumes rcm_far and the checker bind. */
`include "rcm_defs.svh"
module rcm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcm_pkg::*;
  localparam rcm_addr_t AC = `RCM_OFS_CAUSE;
  localparam rcm_addr_t AS = `RCM_OFS_IRQ_STAT;
  localparam rcm_addr_t AM = `RCM_OFS_IRQ_MASK;
  logic      clk_sys = 0, ext_reset_pin_n = 0, wr_en = 0, rd_en = 0, normal_mode = 0, push_low = 0, clk_halt = 0;
  logic      core_supply_por = 0, low_voltage_detect = 0, ecc_fetch_err = 0;
  logic      wdog_main_flag = 0, wdog_one_flag = 0, wdog_two_flag = 0;
  logic      ext_reset_pin_n_i, ext_reset_pin_n_o, ext_reset_pin_n_oe, slow_osc_clock;
  logic      system_clock_tick, hw_reset_n, sw_reset, ecc_irq, irq;
  rcm_addr_t addr = 0;
  rcm_byte_t wr_data = 0;
  rcm_byte_t rd_data;
  int        n_fail = 0, n_compared = 0, n_sw = 0, n_ei = 0;
  always #5 clk_sys = ~clk_sys;
  // pulse counts, so checks do not hinge on the answer cycle
  always @(posedge clk_sys) begin
    n_sw <= n_sw + sw_reset;
    n_ei <= n_ei + ecc_irq;
  end
  rcm_top #(.FILT_CYC(20), .STRETCH_CYC(30)) i_dut (
    .clk_sys, .ext_reset_pin_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .slow_osc_clock, .system_clock_tick,
    .normal_mode, .core_supply_por, .low_voltage_detect, .ext_reset_pin_n_i, .ext_reset_pin_n_o,
    .ext_reset_pin_n_oe, .wdog_main_flag, .wdog_one_flag, .wdog_two_flag, .ecc_fetch_err,
    .hw_reset_n, .sw_reset, .ecc_irq, .irq);
  rcm_far i_far (.clk_sys, .ext_reset_pin_n_o, .ext_reset_pin_n_oe, .push_low, .clk_halt,
    .ext_reset_pin_n_i, .slow_osc_clock, .system_clock_tick);
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input rcm_addr_t a, input rcm_byte_t d);
    addr <= a;
    wr_data <= d;
    rd_en <= 1'h0;
    wr_en <= 1'h1;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    wr_en <= 1'h0;
    rd_en <= 1'h0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rd(input rcm_addr_t a, input rcm_byte_t e, input string nm);
    addr <= a;
    wr_en <= 1'h0;
    rd_en <= 1'h1;
    @(posedge clk_sys);
    rd_en <= 1'h0;
    #1 chk(nm, rd_data, e);
    @(posedge clk_sys);
  endtask
  task automatic wait_hw(input logic v, input int lim);
    for (int k = 0; k < lim && hw_reset_n !== v; k++) @(posedge clk_sys);
    chk("hw_reset_n", hw_reset_n, v);
  endtask
  task automatic hold_pin(input int n);
    push_low <= 1'h1;
    repeat (n) @(posedge clk_sys);
    push_low <= 1'h0;
  endtask
  task automatic ecc_hit();
    ecc_fetch_err <= 1'h1;
    @(posedge clk_sys);
    ecc_fetch_err <= 1'h0;
    idle(3);
  endtask
  task automatic sup_hit(input logic por);
    if (por) core_supply_por <= 1'h1;
    else low_voltage_detect <= 1'h1;
    wait_hw(1'h0, 4);
    core_supply_por <= 1'h0;
    low_voltage_detect <= 1'h0;
    wait_hw(1'h1, 60);
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    ext_reset_pin_n <= 1'h1;
    idle(20);
    chk("hw_reset_n", hw_reset_n, 1'h0);
    wait_hw(1'h1, 40);
    rd(AC, 8'h00, "cause");
    rd(AM, 8'h00, "mask");
    rd(16'ha01a, 8'h00, "unmapped");
    $display("reset test done");
    wr(AM, 8'h01);
    wr(AC, 8'h05);
    wr(AC, 8'h0a);
    idle(3);
    chk("sw count", 8'(n_sw), 8'h01);
    chk("irq", irq, 1'h1);
    rd(AC, 8'h01, "cause");
    rd(AS, 8'h01, "status");
    rd(AS, 8'h00, "status");
    chk("irq", irq, 1'h0);
    wr(AC, 8'h05);
    wr(AC, 8'h00);
    wr(AC, 8'h0a);
    idle(3);
    chk("sw count", 8'(n_sw), 8'h01);
    wr(AC, 8'h10);
    idle(1);
    rd(AC, 8'h00, "cause");
    $display("key test done");
    for (int i = 0; i < 3; i++) begin
      {wdog_two_flag, wdog_one_flag, wdog_main_flag} <= 3'h1 << i;
      @(posedge clk_sys);
      {wdog_two_flag, wdog_one_flag, wdog_main_flag} <= 3'h0;
      idle(3);
      chk("sw count", 8'(n_sw), 8'(2 + i));
      rd(AC, 8'h02, "cause");
      wr(AC, 8'h10);
      idle(1);
    end
    chk("masked irq", irq, 1'h0);
    $display("watchdog test done");
    ecc_hit();
    chk("ecc irq count", 8'(n_ei), 8'h01);
    chk("sw count", 8'(n_sw), 8'h04);
    wr(AC, 8'h40);
    idle(1);
    ecc_hit();
    chk("ecc irq count", 8'(n_ei), 8'h01);
    chk("sw count", 8'(n_sw), 8'h05);
    rd(AC, 8'h04, "cause");
    $display("ecc test done");
    hold_pin(10);
    idle(5);
    chk("hw_reset_n", hw_reset_n, 1'h1);
    hold_pin(25);
    chk("hw_reset_n", hw_reset_n, 1'h0);
    chk("pin oe", ext_reset_pin_n_oe, 1'h1);
    chk("pin drive", ext_reset_pin_n_o, 1'h0);
    wait_hw(1'h1, 60);
    rd(AC, 8'h04, "cause");
    rd(AM, 8'h00, "mask");
    ecc_hit();
    chk("ecc irq count", 8'(n_ei), 8'h02);
    $display("pin test done");
    normal_mode <= 1'h1;
    clk_halt <= 1'h1;
    idle(100);
    chk("hw_reset_n", hw_reset_n, 1'h1);
    clk_halt <= 1'h0;
    idle(2);
    wr(AC, 8'h80);
    idle(1);
    clk_halt <= 1'h1;
    wait_hw(1'h0, 100);
    normal_mode <= 1'h0;
    clk_halt <= 1'h0;
    wait_hw(1'h1, 60);
    rd(AC, 8'h0c, "cause");
    $display("clock monitor test done");
    sup_hit(1'h0);
    rd(AC, 8'h0c, "cause");
    sup_hit(1'h1);
    rd(AC, 8'h00, "cause");
    $display("supply test done");
    wrap_up();
  end
endmodule
